// ### design/tag_bus_regs.vh
`ifndef TAG_BUS_REGS_VH
`define TAG_BUS_REGS_VH
// bus width, with the optional eleventh bit
`define BUS_W 11
`define CYL_W 11
`define HEAD_W 3
`define UNIT_W 4
// control-select bit positions on the bus
`define CTL_WRITE_GATE 0
`define CTL_READ_GATE 1
`define CTL_FAULT_CLEAR 4
`define CTL_RTZ 6
// optional cylinder bit position
`define CYL_MSB_BIT 10
// unit selected answer bound, in ns, and derived cycle count at 10 ns
`define SEL_RESP_NS 200
`define CLK_PERIOD_NS 10
`define SEL_RESP_CYC (`SEL_RESP_NS / `CLK_PERIOD_NS)
// reset values
`define CYL_RESET 11'h000
`define HEAD_RESET 3'h0
`endif

// ### design/pin_sync.v
// two-flop synchroniser for a group of asynchronous pins
module pin_sync #(
  parameter W = 1
) (
  input wire i_clk,
  input wire i_rst,
  input wire [W-1:0] i_async,
  output reg [W-1:0] o_sync
);
  reg [W-1:0] meta;

  // first stage feeds only the second stage
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      meta <= {W{1'b0}};
      o_sync <= {W{1'b0}};
    end else begin
      meta <= i_async;
      o_sync <= meta;
    end
  end
endmodule

// ### design/edge_detect.v
// rising-edge pulse on a group of synchronised levels
module edge_detect #(
  parameter W = 1
) (
  input wire i_clk,
  input wire i_rst,
  input wire [W-1:0] i_level,
  output wire [W-1:0] o_rise
);
  reg [W-1:0] last;

  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      last <= {W{1'b0}};
    end else begin
      last <= i_level;
    end
  end

  assign o_rise = i_level & ~last;
endmodule

// ### design/disk_tag_bus_decoder.v
`include "tag_bus_regs.vh"

module disk_tag_bus_decoder (
  input wire i_clk,
  input wire i_rst,
  // controller side pins
  input wire [`BUS_W-1:0] i_bus,
  input wire i_tag_cyl,
  input wire i_tag_head,
  input wire i_tag_ctl,
  input wire i_unit_tag,
  input wire [`UNIT_W-1:0] i_unit_lines,
  // drive configuration and internal state
  input wire [`UNIT_W-1:0] i_unit_addr,
  input wire i_bit10_enable,
  input wire i_fault_event,
  input wire i_seek_error_event,
  input wire i_seek_done,
  input wire i_at_cyl_zero,
  input wire i_index_mark,
  input wire i_sector_mark,
  input wire i_ready,
  input wire i_write_protect,
  input wire i_write_data,
  input wire i_write_clock,
  input wire i_read_data,
  input wire i_read_clock,
  input wire i_servo_clock,
  // drive-facing outputs
  output reg [`CYL_W-1:0] o_cyl_target,
  output reg o_seek_start,
  output reg [`HEAD_W-1:0] o_head,
  output reg o_write_gate,
  output reg o_read_gate,
  output reg o_rtz_start,
  // status return group, seven lines, only when selected
  output reg o_fault,
  output reg o_seek_error,
  output reg o_on_cylinder,
  output reg o_unit_ready,
  output reg o_write_protected,
  output reg o_index,
  output reg o_sector,
  // radial group
  output reg o_seek_end,
  output reg o_unit_selected,
  output reg o_write_data,
  output reg o_write_clock,
  output reg o_read_data,
  output reg o_read_clock,
  output reg o_servo_clock
);
  wire [`BUS_W-1:0] bus_s;
  wire [2:0] tag_s;
  wire unit_tag_s;
  wire [`UNIT_W-1:0] unit_s;
  wire [3:0] rise;
  wire [2:0] tag_rise;
  wire unit_rise;
  reg selected;
  reg fault;
  reg seek_err;
  reg on_cyl;
  reg seek_busy;
  wire ctl_on;
  wire do_rtz;
  wire do_fclr;

  // every controller pin is asynchronous to the drive clock
  pin_sync #(.W(`BUS_W + 3 + 1 + `UNIT_W)) u_sync (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_async({i_bus, i_tag_cyl, i_tag_head, i_tag_ctl, i_unit_tag,
      i_unit_lines}),
    .o_sync({bus_s, tag_s, unit_tag_s, unit_s})
  );

  // tag 1, tag 2 and select strobes act on their leading edge; tag 3 only for rtz
  edge_detect #(.W(4)) u_edge (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_level({tag_s, unit_tag_s}),
    .o_rise(rise)
  );
  assign tag_rise = rise[3:1];
  assign unit_rise = rise[0];

  // tag 3 is a level enable while selected
  assign ctl_on = selected & tag_s[0];
  assign do_rtz = tag_rise[0] & selected & bus_s[`CTL_RTZ];
  assign do_fclr = ctl_on & bus_s[`CTL_FAULT_CLEAR];

  // selection: latch on leading edge, drop when tag falls
  // two sync flops plus this one stay well inside 200 ns
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      selected <= 1'b0;
    end else if (unit_rise) begin
      selected <= (unit_s == i_unit_addr);
    end else if (!unit_tag_s) begin
      selected <= 1'b0;
    end
  end

  // cylinder capture; a held tag 1 cannot start a second seek
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_cyl_target <= `CYL_RESET;
    end else if (do_rtz) begin
      o_cyl_target <= `CYL_RESET;
    end else if (tag_rise[2] && selected) begin
      // optional top bit is masked unless strapped on
      o_cyl_target <= {bus_s[`CYL_MSB_BIT] & i_bit10_enable,
        bus_s[`CYL_MSB_BIT-1:0]};
    end
  end

  // head capture; only the low three bits carry meaning
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_head <= `HEAD_RESET;
    end else if (do_rtz) begin
      o_head <= `HEAD_RESET;
    end else if (tag_rise[1] && selected) begin
      o_head <= bus_s[`HEAD_W-1:0];
    end
  end

  // one-cycle start pulses; rtz wins over a seek on the same edge
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_seek_start <= 1'b0;
      o_rtz_start <= 1'b0;
    end else begin
      o_rtz_start <= do_rtz;
      o_seek_start <= tag_rise[2] & selected & ~do_rtz;
    end
  end

  // write gate follows its bus bit only while tag 3 is held
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_write_gate <= 1'b0;
    end else begin
      o_write_gate <= ctl_on & bus_s[`CTL_WRITE_GATE];
    end
  end

  // read gate, same level rule as the write gate
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_read_gate <= 1'b0;
    end else begin
      o_read_gate <= ctl_on & bus_s[`CTL_READ_GATE];
    end
  end

  // latched fault; a new fault wins over a clear in the same cycle
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      fault <= 1'b0;
    end else if (i_fault_event) begin
      fault <= 1'b1;
    end else if (do_fclr || do_rtz) begin
      fault <= 1'b0;
    end
  end

  // latched seek error; only a return to zero clears it
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      seek_err <= 1'b0;
    end else if (i_seek_error_event) begin
      seek_err <= 1'b1;
    end else if (do_rtz) begin
      seek_err <= 1'b0;
    end
  end

  // seek in progress; on cylinder drops as soon as a seek starts
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      seek_busy <= 1'b0;
      on_cyl <= 1'b0;
    end else if (o_seek_start || o_rtz_start) begin
      seek_busy <= 1'b1;
      on_cyl <= 1'b0;
    end else if (i_seek_done) begin
      seek_busy <= 1'b0;
      on_cyl <= 1'b1;
    end
  end

  // fault line, held low while another drive owns the bus
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_fault <= 1'b0;
    end else begin
      o_fault <= selected & fault;
    end
  end

  // seek error line, selected drive only
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_seek_error <= 1'b0;
    end else begin
      o_seek_error <= selected & seek_err;
    end
  end

  // on cylinder line, selected drive only
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_on_cylinder <= 1'b0;
    end else begin
      o_on_cylinder <= selected & on_cyl;
    end
  end

  // ready line, selected drive only
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_unit_ready <= 1'b0;
    end else begin
      o_unit_ready <= selected & i_ready;
    end
  end

  // write protected line, selected drive only
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_write_protected <= 1'b0;
    end else begin
      o_write_protected <= selected & i_write_protect;
    end
  end

  // index and sector marks; one flop of delay on both keeps them aligned
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_index <= 1'b0;
      o_sector <= 1'b0;
    end else begin
      o_index <= selected & i_index_mark;
      o_sector <= selected & i_sector_mark;
    end
  end

  // seek end is radial, so it is not gated by selection
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_seek_end <= 1'b0;
    end else begin
      o_seek_end <= (on_cyl | seek_err) & ~seek_busy;
    end
  end

  // unit selected answer, one flop after the selection latch
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_unit_selected <= 1'b0;
    end else begin
      o_unit_selected <= selected;
    end
  end

  // radial write pair, registered to keep outputs flopped
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_write_data <= 1'b0;
      o_write_clock <= 1'b0;
    end else begin
      o_write_data <= i_write_data;
      o_write_clock <= i_write_clock;
    end
  end

  // radial read pair; data stays quiet unless read gate is on
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_read_data <= 1'b0;
      o_read_clock <= 1'b0;
    end else begin
      o_read_data <= i_read_data & o_read_gate;
      o_read_clock <= i_read_clock;
    end
  end

  // servo clock, free running on its radial line
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_servo_clock <= 1'b0;
    end else begin
      o_servo_clock <= i_servo_clock;
    end
  end
endmodule

// ### verif/tag_bus_chk_sva.sv
`include "tag_bus_regs.vh"
// port-level checks; every tag bus action needs its tag, a seek start also selection
module tag_bus_chk (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [`BUS_W-1:0] i_bus,
  input wire logic i_tag_cyl,
  input wire logic i_tag_head,
  input wire logic i_tag_ctl,
  input wire logic i_unit_tag,
  input wire logic [`UNIT_W-1:0] i_unit_lines,
  input wire logic [`UNIT_W-1:0] i_unit_addr,
  input wire logic i_bit10_enable,
  input wire logic [`CYL_W-1:0] o_cyl_target,
  input wire logic o_seek_start,
  input wire logic [`HEAD_W-1:0] o_head,
  input wire logic o_write_gate,
  input wire logic o_read_gate,
  input wire logic o_rtz_start,
  input wire logic o_fault,
  input wire logic o_index,
  input wire logic o_unit_ready,
  input wire logic o_unit_selected
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  a_sel_resp: assert property (
    $rose(i_unit_tag) && i_unit_lines == i_unit_addr
    |-> ##[1:20] o_unit_selected) else $error("select too slow");
  a_sel_drop: assert property (
    !i_unit_tag [*5] |-> !o_unit_selected) else $error("select held");
  a_stat_gate: assert property (
    !o_unit_selected && !$past(o_unit_selected)
    |-> !o_fault && !o_index && !o_unit_ready) else $error("status leak");
  a_seek_cause: assert property (
    o_seek_start |-> $past(i_tag_cyl, 3) && o_unit_selected
    ##1 !o_seek_start) else $error("bad seek pulse");
  a_rtz_cause: assert property (
    o_rtz_start |-> $past(i_tag_ctl, 3) && $past(i_bus[`CTL_RTZ], 3)
    ##1 !o_rtz_start) else $error("bad rtz pulse");
  a_gate_off: assert property (
    !i_tag_ctl [*4] |-> !o_write_gate && !o_read_gate)
    else $error("gate without tag");
  a_bit10_mask: assert property (
    $changed(o_cyl_target) |-> i_bit10_enable || !o_cyl_target[10])
    else $error("bit 10 leaked");
  a_head_cause: assert property (
    $changed(o_head) && o_head != 3'h0 |-> $past(i_tag_head, 3))
    else $error("head moved untagged");
endmodule

bind disk_tag_bus_decoder tag_bus_chk u_chk (.i_clk, .i_rst, .i_bus,
  .i_tag_cyl, .i_tag_head, .i_tag_ctl, .i_unit_tag, .i_unit_lines,
  .i_unit_addr, .i_bit10_enable, .o_cyl_target, .o_seek_start, .o_head,
  .o_write_gate, .o_read_gate, .o_rtz_start, .o_fault, .o_index,
  .o_unit_ready, .o_unit_selected);

// ### verif/tag_ctrl_model.sv
`include "tag_bus_regs.vh"
// controller end: owns the tag bus and the unit select group
module tag_ctrl_model (
  input wire logic i_clk,
  input wire logic i_on_cyl,
  output logic [`BUS_W-1:0] o_bus,
  output logic o_tag_cyl,
  output logic o_tag_head,
  output logic o_tag_ctl,
  output logic o_unit_tag,
  output logic [`UNIT_W-1:0] o_unit_lines
);
  timeunit 1ns;
  timeprecision 100ps;
  // idle bus carries junk so a stale value never looks valid
  initial begin
    o_bus = 11'h2aa;
    {o_tag_cyl, o_tag_head, o_tag_ctl, o_unit_tag} = 4'h0;
    o_unit_lines = 4'h0;
  end
  // lines settle 200 ns before the select tag moves
  task automatic sel(input logic [3:0] u, input logic on);
    @(posedge i_clk) #1 o_unit_lines = u;
    repeat (20) @(posedge i_clk);
    #1 o_unit_tag = on;
  endtask
  // one tagged transfer, bus steady 3 cycles around the tag
  task automatic send(input logic [1:0] t, input logic [10:0] v, input int n);
    while (t == 2'd1 && i_on_cyl !== 1'b1) @(posedge i_clk);
    @(posedge i_clk) #1 o_bus = v;
    repeat (3) @(posedge i_clk);
    #1 {o_tag_ctl, o_tag_head, o_tag_cyl} = 3'b001 << (t - 2'd1);
    repeat (n) @(posedge i_clk);
    #1 {o_tag_ctl, o_tag_head, o_tag_cyl} = 3'b000;
    repeat (3) @(posedge i_clk);
    #1 o_bus = ~v;
  endtask
endmodule

// ### verif/tb.sv
`include "tag_bus_regs.vh"
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [3:0] ADDR = 4'h9; // switch setting under test
  logic i_clk = 1'b0, i_rst = 1'b1, i_bit10_enable = 1'b0;
  logic i_fault_event = 1'b0, i_seek_error_event = 1'b0, i_seek_done = 1'b0;
  logic [3:0] st = 4'h0;
  logic [4:0] rad = 5'h00;
  logic [`BUS_W-1:0] i_bus;
  logic i_tag_cyl, i_tag_head, i_tag_ctl, i_unit_tag;
  logic [`UNIT_W-1:0] i_unit_lines;
  logic [`CYL_W-1:0] o_cyl_target;
  logic [`HEAD_W-1:0] o_head;
  logic o_seek_start, o_write_gate, o_read_gate, o_rtz_start, o_fault;
  logic o_seek_error, o_on_cylinder, o_unit_ready, o_write_protected;
  logic o_index, o_sector, o_unit_selected, o_write_data, o_servo_clock;
  logic o_seek_end, o_write_clock, o_read_data, o_read_clock;
  int error_cnt = 0, checks_done = 0, cyc = 0, n_seek = 0, n_rtz = 0;
  int n_wg = 0, n_rg = 0, k;
  always #5 i_clk = ~i_clk;
  disk_tag_bus_decoder uut (.i_clk, .i_rst, .i_bus, .i_tag_cyl, .i_tag_head,
    .i_tag_ctl, .i_unit_tag, .i_unit_lines, .i_unit_addr(ADDR),
    .i_bit10_enable, .i_fault_event, .i_seek_error_event, .i_seek_done,
    .i_at_cyl_zero(1'b0), .i_index_mark(st[3]), .i_sector_mark(st[2]),
    .i_ready(st[1]), .i_write_protect(st[0]), .i_write_data(rad[4]),
    .i_write_clock(rad[3]), .i_read_data(rad[2]), .i_read_clock(rad[1]),
    .i_servo_clock(rad[0]), .o_cyl_target, .o_seek_start, .o_head,
    .o_write_gate, .o_read_gate, .o_rtz_start, .o_fault, .o_seek_error,
    .o_on_cylinder, .o_unit_ready, .o_write_protected, .o_index, .o_sector,
    .o_seek_end, .o_unit_selected, .o_write_data, .o_write_clock,
    .o_read_data, .o_read_clock, .o_servo_clock);
  tag_ctrl_model ctl (.i_clk, .i_on_cyl(o_on_cylinder), .o_bus(i_bus),
    .o_tag_cyl(i_tag_cyl), .o_tag_head(i_tag_head), .o_tag_ctl(i_tag_ctl),
    .o_unit_tag(i_unit_tag), .o_unit_lines(i_unit_lines));
  // pulse counters, since pulses last one cycle only; hang guard too
  always @(posedge i_clk) begin
    cyc++;
    if (o_seek_start === 1'b1) n_seek++;
    if (o_rtz_start === 1'b1) n_rtz++;
    if (o_write_gate === 1'b1) n_wg++;
    if (o_read_gate === 1'b1) n_rg++;
    if (cyc == 5000) begin
      error_cnt++;
      wrap_up;
    end
  end
  task cmp(input string n, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task wrap_up;
    if (error_cnt == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic pulse(ref logic s);
    @(posedge i_clk) #1 s = 1'b1;
    @(posedge i_clk) #1 s = 1'b0;
    repeat (3) @(posedge i_clk);
  endtask
  task ctl_op(input logic [10:0] v, input logic [2:0] e);
    n_wg = 0;
    n_rg = 0;
    n_rtz = 0;
    ctl.send(2'd3, v, 6);
    cmp("wg_rg_rtz", {8'h00, e}, {8'h00, n_wg != 0, n_rg != 0, n_rtz == 1});
  endtask
  task t_select;
    ctl.sel(4'h3, 1'b1);
    repeat (10) @(posedge i_clk);
    cmp("sel_other", 0, o_unit_selected);
    ctl.send(2'd2, 11'h005, 8);
    cmp("head_unsel", 0, o_head);
    ctl.sel(4'h3, 1'b0);
    ctl.sel(ADDR, 1'b1);
    k = 0;
    while (o_unit_selected !== 1'b1 && k < 40) begin
      @(posedge i_clk) #1;
      k++;
    end
    cmp("sel_within", 1, k <= 20);
  endtask
  task t_cyl;
    pulse(i_seek_done);
    cmp("on_cyl", 1, o_on_cylinder);
    cmp("seek_end", 1, o_seek_end);
    ctl.send(2'd1, 11'h7ff, 8);
    cmp("cyl_masked", 11'h3ff, o_cyl_target);
    cmp("seek_pulses", 1, n_seek[10:0]);
    cmp("seek_end_busy", 0, o_seek_end);
    pulse(i_seek_done);
    #1 i_bit10_enable = 1'b1;
    ctl.send(2'd1, 11'h5a5, 8);
    cmp("cyl_bit10", 11'h5a5, o_cyl_target);
  endtask
  task t_ctl;
    ctl.send(2'd2, 11'h7fd, 8);
    cmp("head", 11'h005, o_head);
    ctl_op(11'h001, 3'b100);
    ctl_op(11'h002, 3'b010);
    ctl_op(11'h7ac, 3'b000);
    cmp("head_kept", 11'h005, o_head);
    pulse(i_seek_error_event);
    cmp("seek_err", 1, o_seek_error);
    ctl_op(11'h040, 3'b001);
    cmp("rtz_state", 0, {o_cyl_target, o_head, o_seek_error});
  endtask
  task t_status;
    pulse(i_fault_event);
    cmp("fault", 1, o_fault);
    ctl_op(11'h010, 3'b000);
    cmp("fault_clear", 0, o_fault);
    st = 4'hf;
    rad = 5'h1f;
    repeat (4) @(posedge i_clk);
    cmp("status_on", 4'hf, {o_index, o_sector, o_unit_ready,
      o_write_protected});
    cmp("radial", 5'h1b, {o_write_data, o_write_clock, o_read_data,
      o_read_clock, o_servo_clock});
    ctl.sel(ADDR, 1'b0);
    repeat (6) @(posedge i_clk);
    cmp("status_off", 0, {o_index, o_sector, o_unit_ready,
      o_write_protected, o_unit_selected});
  endtask
  initial begin
    repeat (10) @(posedge i_clk);
    #1 i_rst = 1'b0;
    t_select;
    t_cyl;
    t_ctl;
    t_status;
    wrap_up;
  end
endmodule
